// File: hdl/pmec_regs.vh
`ifndef PMEC_REGS_VH
`define PMEC_REGS_VH
// ==========================================
// Register offsets (byte address = offset)
`define PMEC_ADDR_W 12
`define PMEC_OFS_PAT_HIGH 12'h090d
`define PMEC_OFS_PAT_LOW 12'h090e
`define PMEC_OFS_SLIP 12'h090f
`define PMEC_OFS_ZV_HIGH 12'h0910
`define PMEC_OFS_ZV_LOW 12'h0911
`define PMEC_OFS_INT_STAT 12'h0920
`define PMEC_OFS_INT_MASK 12'h0921
// ==========================================
// Reset values and field positions
`define PMEC_RST_BYTE 8'h00
`define PMEC_RST_WORD 16'h0000
`define PMEC_ONE_WORD 16'h0001
`define PMEC_INT_PAT 0
`define PMEC_INT_SLIP 1
`define PMEC_INT_ZV 2
`define PMEC_INT_W 3
`define PMEC_RST_INT 3'h0
`endif

// File: hdl/pmec_counter.v
`timescale 1ns/1ps
`default_nettype none
`include "pmec_regs.vh"
// ==========================================
// Clear-on-read saturating event counter
module pmec_counter #(
	parameter WIDTH = 16
) (
	// Clock and reset
	input wire clock,
	input wire arst_n,
	// Event and clear
	input wire event_pulse,
	input wire clear,
	// Count
	output reg [WIDTH-1:0] count_q
);
	wire [WIDTH-1:0] one_w = {{(WIDTH-1){1'b0}}, 1'b1};
	reg [WIDTH-1:0] count_d;

	always @* begin
		count_d = count_q;
		if (clear)
			count_d = event_pulse ? one_w : {WIDTH{1'b0}}; // [R11]
		else if (event_pulse && (count_q != {WIDTH{1'b1}}))
			count_d = count_q + one_w;
	end

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			count_q <= {WIDTH{1'b0}};
		else
			count_q <= count_d;
	end
endmodule // pmec_counter
`default_nettype wire

// File: hdl/pmec_irq.v
`timescale 1ns/1ps
`default_nettype none
`include "pmec_regs.vh"
// ==========================================
// Sticky status, write-one-to-clear, masked
module pmec_irq #(
	parameter N = 3
) (
	// Clock and reset
	input wire clock,
	input wire arst_n,
	// Events and software
	input wire [N-1:0] events,
	input wire [N-1:0] clear_bits,
	input wire [N-1:0] mask_q,
	// Status
	output reg [N-1:0] status_q,
	output wire irq
);
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			status_q <= {N{1'b0}};
		else
			// Set wins over a same-cycle clear
			status_q <= (status_q & ~clear_bits) | events;
	end

	assign irq = |(status_q & mask_q);
endmodule // pmec_irq
`default_nettype wire

// File: hdl/pmec_top.v
// Functional notes
// [R1] Receive test-pattern bit errors are counted in a 16-bit counter since its last read.
// [R2] The low byte of that count is read at the pattern low-byte register.
// [R3] Software reads the high byte of a 16-bit counter before its low byte.
// [R4] Reading the high byte then the low byte clears a 16-bit counter.
// [R5] Transmit slips are counted in an 8-bit counter since its last read.
// [R6] A slip is a repeated or dropped whole frame in the transmit slip buffer.
// [R7] The slip counter reads its total and returns to zero.
// [R8] Excessive-zero violations are counted in a 16-bit clear-on-read counter.
// [R9] The high byte of the violation count is read at the violation high-byte register.
// [R10] A high-byte read latches the low byte, which the low-byte read then returns.
// [R11] An event coinciding with a clearing read restarts the count at one.
`timescale 1ns/1ps
`default_nettype none
`include "pmec_regs.vh"
module pmec_top (
	// Clock and reset
	input wire clock,
	input wire arst_n,
	// Event pulses
	input wire pattern_bit_error,
	input wire tx_frame_repeat,
	input wire tx_frame_drop,
	input wire zero_violation,
	// Register port
	input wire [`PMEC_ADDR_W-1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [7:0] reg_rdata_q,
	// Interrupt
	output wire irq
);
	// ==========================================
	// Decode
	wire rd_pat_hi = reg_read && (reg_addr == `PMEC_OFS_PAT_HIGH);
	wire rd_pat_lo = reg_read && (reg_addr == `PMEC_OFS_PAT_LOW);
	wire rd_slip = reg_read && (reg_addr == `PMEC_OFS_SLIP);
	wire rd_zv_hi = reg_read && (reg_addr == `PMEC_OFS_ZV_HIGH);
	wire rd_zv_lo = reg_read && (reg_addr == `PMEC_OFS_ZV_LOW);
	wire wr_stat = reg_write && (reg_addr == `PMEC_OFS_INT_STAT);
	wire wr_mask = reg_write && (reg_addr == `PMEC_OFS_INT_MASK);

	// ==========================================
	// Counters
	wire [15:0] pattern_bit_error_count;
	wire [7:0] tx_frame_slip_count;
	wire [15:0] zero_violation_count;
	reg [7:0] pat_hold_q;
	reg [7:0] zv_hold_q;
	reg pat_armed_q;
	reg zv_armed_q;
	wire slip_event = tx_frame_repeat | tx_frame_drop; // [R6]
	// Clear only on low-byte read after a high-byte read
	wire pat_clear = rd_pat_lo && pat_armed_q; // [R4]
	wire zv_clear = rd_zv_lo && zv_armed_q; // [R4]

	pmec_counter #(.WIDTH(16)) u_pat (
		.clock(clock),
		.arst_n(arst_n),
		.event_pulse(pattern_bit_error), // [R1]
		.clear(pat_clear),
		.count_q(pattern_bit_error_count)
	);

	pmec_counter #(.WIDTH(8)) u_slip (
		.clock(clock),
		.arst_n(arst_n),
		.event_pulse(slip_event), // [R5]
		.clear(rd_slip), // [R7]
		.count_q(tx_frame_slip_count)
	);

	pmec_counter #(.WIDTH(16)) u_zv (
		.clock(clock),
		.arst_n(arst_n),
		.event_pulse(zero_violation), // [R8]
		.clear(zv_clear),
		.count_q(zero_violation_count)
	);

	// ==========================================
	// Low-byte holding
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pat_hold_q <= `PMEC_RST_BYTE;
			zv_hold_q <= `PMEC_RST_BYTE;
			pat_armed_q <= 1'b0;
			zv_armed_q <= 1'b0;
		end else begin
			if (rd_pat_hi) begin
				pat_hold_q <= pattern_bit_error_count[7:0]; // [R10]
				pat_armed_q <= 1'b1;
			end else if (rd_pat_lo) begin
				pat_armed_q <= 1'b0;
			end
			if (rd_zv_hi) begin
				zv_hold_q <= zero_violation_count[7:0]; // [R10]
				zv_armed_q <= 1'b1;
			end else if (rd_zv_lo) begin
				zv_armed_q <= 1'b0;
			end
		end
	end

	// ==========================================
	// Interrupts
	reg [`PMEC_INT_W-1:0] mask_q;
	wire [`PMEC_INT_W-1:0] status;
	wire [`PMEC_INT_W-1:0] events = {zero_violation, slip_event, pattern_bit_error};
	wire [`PMEC_INT_W-1:0] clr = wr_stat ? reg_wdata[`PMEC_INT_W-1:0] : `PMEC_RST_INT;

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			mask_q <= `PMEC_RST_INT;
		else if (wr_mask)
			mask_q <= reg_wdata[`PMEC_INT_W-1:0];
	end

	pmec_irq #(.N(`PMEC_INT_W)) u_irq (
		.clock(clock),
		.arst_n(arst_n),
		.events(events),
		.clear_bits(clr),
		.mask_q(mask_q),
		.status_q(status),
		.irq(irq)
	);

	// ==========================================
	// Read data, valid only the cycle after a read
	reg [7:0] rdata_d;
	always @* begin
		rdata_d = `PMEC_RST_BYTE;
		if (reg_read) begin
			case (reg_addr)
				`PMEC_OFS_PAT_HIGH: rdata_d = pattern_bit_error_count[15:8];
				// Without a prior high read, show the live byte
				`PMEC_OFS_PAT_LOW: rdata_d = pat_armed_q ? pat_hold_q
					: pattern_bit_error_count[7:0]; // [R2]
				`PMEC_OFS_SLIP: rdata_d = tx_frame_slip_count; // [R7]
				`PMEC_OFS_ZV_HIGH: rdata_d = zero_violation_count[15:8]; // [R9]
				`PMEC_OFS_ZV_LOW: rdata_d = zv_armed_q ? zv_hold_q
					: zero_violation_count[7:0];
				`PMEC_OFS_INT_STAT: rdata_d = {5'h00, status};
				`PMEC_OFS_INT_MASK: rdata_d = {5'h00, mask_q};
				default: rdata_d = `PMEC_RST_BYTE;
			endcase
		end
	end

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			reg_rdata_q <= `PMEC_RST_BYTE;
		else
			reg_rdata_q <= rdata_d;
	end
endmodule // pmec_top
`default_nettype wire

// File: testbench/pmec_props.sv
`timescale 1ns/1ps
`default_nettype none
module pmec_props (
	// Clock and reset
	input wire clock,
	input wire arst_n,
	// Watched ports
	input wire pattern_bit_error,
	input wire tx_frame_repeat,
	input wire tx_frame_drop,
	input wire [11:0] reg_addr,
	input wire reg_write,
	input wire reg_read,
	input wire [7:0] reg_rdata_q,
	input wire irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	wire sl = tx_frame_repeat | tx_frame_drop;
	wire [7:0] ra = (reg_read && reg_addr[11:8] == 4'h9) ? reg_addr[7:0] : 8'h00;
	wire rs = ra == 8'h0f;
	wire ph = ra == 8'h0d;
	wire pl = ra == 8'h0e;
	wire zh = ra == 8'h10;
	wire zl = ra == 8'h11;
	// ========
	// Read-side and interrupt checks
	idle_zero_a: assert property (!reg_read |=> reg_rdata_q == 8'h00) else $error("idle data");
	slip_clear_a: assert property ((rs && !sl) ##1 rs |=> reg_rdata_q == 8'h00)
		else $error("slip kept");
	slip_restart_a: assert property ((rs && sl) ##1 rs |=> reg_rdata_q == 8'h01)
		else $error("slip lost");
	slip_count_a: assert property ((rs && !sl) ##1 (sl && !reg_read) ##1 rs
		|=> reg_rdata_q == 8'h01) else $error("slip count");
	pat_clear_a: assert property (ph ##1 pl ##1 ph |=> reg_rdata_q == 8'h00)
		else $error("pattern kept");
	pat_live_a: assert property (ph ##1 (pl && !pattern_bit_error) ##1
		(pattern_bit_error && !reg_read) ##1 pl |=> reg_rdata_q == 8'h01) else $error("pattern");
	zv_clear_a: assert property (zh ##1 zl ##1 zh |=> reg_rdata_q == 8'h00)
		else $error("violation kept");
	irq_fall_a: assert property ($fell(irq) |-> $past(reg_write)) else $error("irq fell");
	cover property (rs ##1 rs);
	cover property (ph ##1 pl);
	cover property ($rose(irq));
endmodule // pmec_props
bind pmec_top pmec_props i_pmec_props (.clock(clock), .arst_n(arst_n),
	.pattern_bit_error(pattern_bit_error), .tx_frame_repeat(tx_frame_repeat),
	.tx_frame_drop(tx_frame_drop), .reg_addr(reg_addr), .reg_write(reg_write),
	.reg_read(reg_read), .reg_rdata_q(reg_rdata_q), .irq(irq));
`default_nettype wire

// File: testbench/tb_pmec_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pmec_top;
	logic clock = 0, arst_n = 0, rd_stb = 0, wr_stb = 0, rchk = 0;
	logic [3:0] ev = 4'h0;
	logic [11:0] addr = 12'h0000;
	logic [7:0] wdata = 8'h00, rexp = 8'h00, rexp_d = 8'h00;
	wire [7:0] rdata;
	wire irq;
	int failures = 0, checks = 0;
	pmec_top i_pmec_top (.clock(clock), .arst_n(arst_n), .pattern_bit_error(ev[3]),
		.tx_frame_repeat(ev[2]), .tx_frame_drop(ev[1]), .zero_violation(ev[0]),
		.reg_addr(addr), .reg_wdata(wdata), .reg_write(wr_stb), .reg_read(rd_stb),
		.reg_rdata_q(rdata), .irq(irq));
	always #2.5 clock = ~clock;
	// ========
	// Tasks
	task chk(input string n, input logic [7:0] s, e);
		checks++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task cyc(input logic r, w, input logic [7:0] a, d, e, input logic [3:0] v);
		@(posedge clock);
		{rd_stb, wr_stb, addr, wdata, rexp, ev} <= {r, w, 4'h9, a, d, e, v};
	endtask
	task rd(input logic [7:0] a, e, input logic [3:0] v = 4'h0);
		cyc(1, 0, a, 8'h00, e, v);
	endtask
	task idle(input logic [3:0] v);
		cyc(0, 0, 8'h00, 8'h00, 8'h00, v);
	endtask
	task irq_is(input logic e);
		idle(4'h0);
		@(negedge clock);
		chk("irq", {7'h00, irq}, {7'h00, e});
	endtask
	task report_and_stop;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Read data stands only in the cycle after the strobe
	always @(posedge clock) {rchk, rexp_d} <= {rd_stb, rexp};
	always @(negedge clock) if (rchk) chk("read data", rdata, rexp_d);
	// ========
	// Tests
	initial begin
		repeat (20) @(posedge clock);
		arst_n <= 1'b1;
		rd(8'h0e, 8'h00);
		rd(8'h0f, 8'h00);
		rd(8'h10, 8'h00);
		rd(8'h00, 8'h00);
		$display("reset test done");
		repeat (260) idle(4'h8);
		rd(8'h0d, 8'h01);
		idle(4'h8);
		rd(8'h0e, 8'h04);
		rd(8'h0d, 8'h00);
		rd(8'h0e, 8'h00);
		idle(4'h8);
		rd(8'h0e, 8'h01);
		rd(8'h0d, 8'h00);
		rd(8'h0e, 8'h01, 4'h8);
		rd(8'h0d, 8'h00);
		rd(8'h0e, 8'h01);
		$display("pattern test done");
		idle(4'h4);
		idle(4'h2);
		idle(4'h6);
		rd(8'h0f, 8'h03);
		rd(8'h0f, 8'h00, 4'h4);
		rd(8'h0f, 8'h01);
		idle(4'h6);
		rd(8'h0f, 8'h01);
		$display("slip test done");
		repeat (257) idle(4'h1);
		rd(8'h10, 8'h01);
		rd(8'h11, 8'h01);
		rd(8'h10, 8'h00);
		rd(8'h11, 8'h00);
		$display("violation test done");
		irq_is(1'b0);
		rd(8'h20, 8'h07);
		cyc(0, 1, 8'h21, 8'h07, 8'h00, 4'h0);
		irq_is(1'b1);
		rd(8'h21, 8'h07);
		cyc(0, 1, 8'h20, 8'h07, 8'h00, 4'h0);
		irq_is(1'b0);
		rd(8'h20, 8'h00);
		idle(4'h8);
		irq_is(1'b1);
		rd(8'h20, 8'h01);
		cyc(0, 1, 8'h21, 8'h06, 8'h00, 4'h0);
		irq_is(1'b0);
		$display("interrupt test done");
		report_and_stop();
	end
	// Run takes about 3 us; far beyond that means a hang
	initial begin
		#20000;
		failures++;
		report_and_stop();
	end
endmodule // tb_pmec_top
`default_nettype wire
